// *** hdl/link_phy_defs.svh ***
// constants for the link/phy boundary block
`ifndef LINK_PHY_DEFS_SVH
`define LINK_PHY_DEFS_SVH
`define CLK_NS          100
`define SB_BIT_NS       1000
`define SB_HALF_CYC     (`SB_BIT_NS / (2 * `CLK_NS))
`define SB_PRE_BITS     16
`define SB_SYNC_HALVES  8
`define SB_TAIL_HALVES  8
`define CMD_WAIT_MS     100
`define CMD_WAIT_CYC    (`CMD_WAIT_MS * 1000000 / `CLK_NS)
`define IRQ_LOW_US      1000
`define IRQ_LOW_CYC     (`IRQ_LOW_US * 1000 / `CLK_NS)
`define NUM_LANES       4
`define SCR_SEED        16'hffff
`define SCR_RESET_SYM   8'h1c
`define ID_SEG_BITS     7
`define ID_OFS_BITS     8
`endif

// *** hdl/link_phy_pkg.sv ***
// shared types for the link/phy boundary block
package link_phy_pkg;
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } sb_word_t;
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } lane_sym_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PRE  = 3'h1,
    TX_SYNC = 3'h3,
    TX_DATA = 3'h2,
    TX_STOP = 3'h6
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_SYNC = 2'h1,
    RX_DATA = 2'h3,
    RX_TAIL = 2'h2
  } rx_state_t;
endpackage

// *** hdl/link_phy_hot_plug.sv ***
// link/phy boundary: hot plug, sideband manchester channel, main lanes
// Overview of operation
// - identity address joins segment pointer and offset, 32K bytes.
// - identity bus transfers ride as sideband requests and replies.
// - sink event pulses the hot plug line low to notify source.
// - pending command read must follow hot plug rise within 100 ms.
// - hot plug line changes reported as plug status and events.
// - plug status passes undebounced; link layer owns the timer.
// - sideband word is eight data bits plus one control bit.
// - each main lane carries eight data bits plus one control bit.
// - lane control bit marks framing symbols; others are data.
// - sideband start, stop and sync pattern generated and detected.
// - sideband bits are manchester coded and decoded.
// - sideband is half duplex; only one end drives at a time.
// - main link flows one way, source to sink.
// - main lanes scramble data symbols before the serial stage.
// - drive current and pre-emphasis settings applied per training.
// - one to four lanes, each with its own byte interface.
// - sideband accepted whenever hot plug line is driven high.
// - sideband activity still watched in power saving mode.
// - power saving exits within 1 ms of sideband activity.
// - hot plug sensing may be disabled for embedded links.
`include "link_phy_defs.svh"
module link_phy_hot_plug
  import link_phy_pkg::*;
#(
  parameter int CMD_WAIT_CYC = `CMD_WAIT_CYC,
  parameter int IRQ_LOW_CYC  = `IRQ_LOW_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    hpdIn,
  input  wire logic                    hpdUsed,
  output logic                         plugStatus,
  output logic                         plugEvent,
  output logic                         unplugEvent,
  input  wire logic                    hpdEnable,
  input  wire logic                    sinkEvent,
  input  wire logic                    cmdPending,
  input  wire logic                    cmdRead,
  output logic                         hpdDrive,
  output logic                         cmdLate,
  input  wire logic                    powerSaveReq,
  output logic                         lowPower,
  output logic                         sbReady,
  input  wire sb_word_t                txWord,
  input  wire logic                    txValid,
  output logic                         txReady,
  output logic                         sbOut,
  output logic                         sbOe,
  input  wire logic                    sbIn,
  output sb_word_t                     rxWord,
  output logic                         rxValid,
  input  wire lane_sym_t [`NUM_LANES-1:0] laneIn,
  input  wire logic [1:0]              laneCountM1,
  input  wire logic                    scrambleOn,
  output lane_sym_t [`NUM_LANES-1:0]   laneOut,
  input  wire logic [1:0]              driveSet,
  input  wire logic [1:0]              preEmphSet,
  output logic [1:0]                   driveLevel,
  output logic [1:0]                   preEmph,
  input  wire logic [`ID_SEG_BITS-1:0] idSegment,
  input  wire logic [`ID_OFS_BITS-1:0] idOffset,
  output logic [14:0]                  idAddr
);
  localparam logic [7:0] HALF = 8'(`SB_HALF_CYC);
  localparam logic [7:0] MID_MIN = 8'(3 * `SB_HALF_CYC / 2);
  localparam logic [7:0] LONG = 8'(3 * `SB_HALF_CYC);
  localparam logic [7:0] LONG_MID = 8'(9 * `SB_HALF_CYC / 2);
  localparam logic [7:0] TAIL = 8'(`SB_TAIL_HALVES * `SB_HALF_CYC);

  // scrambler: x^16+x^5+x^4+x^3+1, eight steps per symbol
  function automatic logic [23:0] scramble(input logic [7:0] d,
                                           input logic [15:0] s);
    logic [15:0] st;
    logic [7:0]  o;
    logic        fb;
    st = s;
    o = d;
    for (int b = 0; b < 8; b++) begin
      fb = st[15];
      o[b] = d[b] ^ fb;
      st = {st[14:0], 1'b0} ^ (fb ? 16'h0039 : 16'h0000);
    end
    return {st, o};
  endfunction

  // hot plug sensing and sink side drive
  logic        hpdPrev, next_plugStatus, next_hpdPrev;
  logic        next_plugEvent, next_unplugEvent, next_hpdDrive;
  logic        pend, next_pend, next_cmdLate, waitOn, next_waitOn;
  logic [19:0] irqCnt, next_irqCnt, waitCnt, next_waitCnt;
  logic        hpdLevel;
  assign hpdLevel = hpdUsed ? hpdIn : 1'b1;
  always_comb begin
    next_hpdPrev = hpdLevel;
    next_plugStatus = hpdLevel;
    next_plugEvent = hpdLevel & ~hpdPrev;
    next_unplugEvent = ~hpdLevel & hpdPrev;
    next_irqCnt = irqCnt;
    next_pend = pend;
    next_waitOn = waitOn;
    next_waitCnt = waitCnt;
    next_cmdLate = 1'b0;
    if (irqCnt != 20'h00000) begin
      next_irqCnt = irqCnt - 20'h00001;
    end else if (hpdEnable && (sinkEvent || cmdPending)) begin
      next_irqCnt = 20'(IRQ_LOW_CYC);
    end
    next_hpdDrive = hpdEnable && (next_irqCnt == 20'h00000);
    if (cmdRead) begin
      next_pend = 1'b0;
      next_waitOn = 1'b0;
    end
    if (waitOn) begin
      next_waitCnt = waitCnt + 20'h00001;
      if (waitCnt == 20'(CMD_WAIT_CYC - 1) && !cmdRead) begin
        next_cmdLate = 1'b1;
        next_waitOn = 1'b0;
      end
    end
    // pending set beats a read in the same cycle
    if (cmdPending && hpdEnable) begin
      next_pend = 1'b1;
    end
    if (pend && !hpdDrive && next_hpdDrive) begin
      next_waitOn = 1'b1; // timed from the rising edge
      next_waitCnt = 20'h00000;
    end
  end

  // power saving: any sideband edge while sbOe is low wakes the sink
  logic sbPrev, psPrev, next_lowPower, activity;
  assign activity = (sbIn ^ sbPrev) & ~sbOe;
  always_comb begin
    next_lowPower = lowPower;
    if (lowPower && (activity || !powerSaveReq)) begin
      next_lowPower = 1'b0;
    end else if (powerSaveReq && !psPrev && !activity) begin
      next_lowPower = 1'b1;
    end
  end
  // rx path never gated by lowPower, so a frame is never refused
  assign sbReady = hpdDrive;

  // two-entry buffer on the sideband transmit path
  sb_word_t  buffer [2];
  logic      wrPtr, rdPtr, next_wrPtr, next_rdPtr, pop;
  logic [1:0] count, next_count;
  sb_word_t  head;
  assign txReady = (count != 2'h2);
  assign head = buffer[rdPtr];
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (txValid && txReady) begin
      next_wrPtr = ~wrPtr;
      next_count = next_count + 2'h1;
    end
    if (pop) begin
      next_rdPtr = ~rdPtr;
      next_count = next_count - 2'h1;
    end
  end

  // manchester transmitter: a one is high then low
  tx_state_t  txState, next_txState;
  logic [7:0] halfCnt, next_halfCnt, txShift, next_txShift;
  logic [5:0] halfIdx, next_halfIdx;
  logic       tick, lastHalf, next_sbOut;
  assign tick = (halfCnt == HALF - 8'h01);
  always_comb begin
    next_txState = txState;
    next_halfCnt = tick ? 8'h00 : halfCnt + 8'h01;
    next_halfIdx = halfIdx;
    next_txShift = txShift;
    pop = 1'b0;
    lastHalf = 1'b0;
    case (txState)
      TX_IDLE: begin
        next_halfCnt = 8'h00;
        next_halfIdx = 6'h00;
        if (count != 2'h0 && head.ctrl) begin
          next_txState = TX_PRE;
        end else if (count != 2'h0) begin
          pop = 1'b1; // stray word outside a frame
        end
      end
      TX_PRE: lastHalf = (halfIdx == 6'(2 * `SB_PRE_BITS - 1));
      TX_SYNC, TX_STOP: lastHalf = (halfIdx == 6'(`SB_SYNC_HALVES - 1));
      default: lastHalf = (halfIdx == 6'h0f);
    endcase
    if (tick && txState != TX_IDLE) begin
      next_halfIdx = lastHalf ? 6'h00 : halfIdx + 6'h01;
      if (lastHalf) begin
        case (txState)
          TX_PRE: next_txState = TX_SYNC;
          TX_STOP: next_txState = TX_IDLE;
          default: begin
            if (count != 2'h0 && !(txState == TX_DATA && head.ctrl)) begin
              next_txShift = head.data;
              pop = 1'b1;
              next_txState = TX_DATA;
            end else begin
              pop = (count != 2'h0); // stop token, or underrun closes
              next_txState = TX_STOP;
            end
          end
        endcase
      end
    end
    case (next_txState)
      TX_PRE: next_sbOut = next_halfIdx[0];
      TX_SYNC, TX_STOP: next_sbOut = next_halfIdx[2];
      TX_DATA: begin
        next_sbOut = next_txShift[3'(7 - 32'(next_halfIdx[3:1]))]
                     ^ next_halfIdx[0];
      end
      default: next_sbOut = 1'b0;
    endcase
  end

  // manchester receiver: run lengths tell mid-bit from boundary edges
  rx_state_t  rxState, next_rxState;
  logic [7:0] runCnt, next_runCnt, rxShift, next_rxShift;
  logic [2:0] bitCnt, next_bitCnt;
  logic       firstByte, next_firstByte, next_rxValid, edgeSeen;
  sb_word_t   next_rxWord;
  assign edgeSeen = sbIn ^ sbPrev;
  always_comb begin
    next_rxState = rxState;
    next_runCnt = (runCnt == 8'hff) ? runCnt : runCnt + 8'h01;
    next_rxShift = rxShift;
    next_bitCnt = bitCnt;
    next_firstByte = firstByte;
    next_rxValid = 1'b0;
    next_rxWord = rxWord;
    if (sbOe) begin
      next_rxState = RX_HUNT;
      next_runCnt = 8'h00;
    end else begin
      case (rxState)
        RX_HUNT: begin
          if (edgeSeen) begin
            next_runCnt = 8'h00;
            if (runCnt >= LONG && runCnt < LONG_MID) begin
              next_rxState = RX_SYNC;
            end
          end
        end
        RX_SYNC: begin
          next_bitCnt = 3'h0;
          next_firstByte = 1'b1;
          if (edgeSeen) begin
            next_rxState = (runCnt >= LONG) ? RX_DATA : RX_HUNT;
            next_runCnt = HALF;
            if (runCnt >= LONG_MID) begin
              next_runCnt = 8'h00;
              next_rxShift = {rxShift[6:0], ~sbIn};
              next_bitCnt = 3'h1;
            end
          end
        end
        RX_DATA: begin
          if (edgeSeen && runCnt >= MID_MIN) begin
            next_runCnt = 8'h00;
            next_rxShift = {rxShift[6:0], ~sbIn};
            next_bitCnt = bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              next_rxValid = 1'b1;
              next_rxWord = '{ctrl: firstByte, data: next_rxShift};
              next_firstByte = 1'b0;
            end
          end else if (!edgeSeen && runCnt == LONG) begin
            next_rxValid = 1'b1; // stop token; partial byte dropped
            next_rxWord = '{ctrl: 1'b1, data: 8'h00};
            next_rxState = RX_TAIL;
          end
        end
        default: begin
          if (edgeSeen) begin
            next_runCnt = 8'h00;
          end else if (runCnt == TAIL) begin
            next_rxState = RX_HUNT;
          end
        end
      endcase
    end
  end

  // main lanes, source to sink only; control symbols skip scrambling
  logic [15:0] scr [`NUM_LANES];
  lane_sym_t   laneReg [`NUM_LANES];
  genvar g;
  generate
    for (g = 0; g < `NUM_LANES; g++) begin : gLane
      logic [23:0] res;
      logic [15:0] next_scr;
      lane_sym_t   next_sym;
      always_comb begin
        res = scramble(laneIn[g].data, scr[g]);
        next_scr = res[23:8];
        next_sym = '{ctrl: laneIn[g].ctrl, data: res[7:0]};
        if (laneIn[g].ctrl || !scrambleOn) begin
          next_sym = laneIn[g];
          next_scr = scr[g];
        end
        if (laneIn[g].ctrl && laneIn[g].data == `SCR_RESET_SYM) begin
          next_scr = `SCR_SEED;
        end
        if (2'(g) > laneCountM1) begin
          next_sym = '0;
        end
      end
      always_ff @(posedge clock) begin
        if (srst) begin
          scr[g] <= `SCR_SEED;
          laneReg[g] <= '0;
        end else if (ce) begin
          scr[g] <= next_scr;
          laneReg[g] <= next_sym;
        end
      end
    end
  endgenerate
  // one process packs the lanes so the output keeps a single driver
  always_comb begin
    for (int i = 0; i < `NUM_LANES; i++) begin
      laneOut[i] = laneReg[i];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hpdPrev <= 1'b0;
      plugStatus <= 1'b0;
      plugEvent <= 1'b0;
      unplugEvent <= 1'b0;
      irqCnt <= 20'h00000;
      hpdDrive <= 1'b0;
      pend <= 1'b0;
      waitOn <= 1'b0;
      waitCnt <= 20'h00000;
      cmdLate <= 1'b0;
      sbPrev <= 1'b0;
      psPrev <= 1'b0;
      lowPower <= 1'b0;
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
      buffer[0] <= '0;
      buffer[1] <= '0;
      txState <= TX_IDLE;
      halfCnt <= 8'h00;
      halfIdx <= 6'h00;
      txShift <= 8'h00;
      sbOut <= 1'b0;
      sbOe <= 1'b0;
      rxState <= RX_HUNT;
      runCnt <= 8'h00;
      rxShift <= 8'h00;
      bitCnt <= 3'h0;
      firstByte <= 1'b0;
      rxValid <= 1'b0;
      rxWord <= '0;
      driveLevel <= 2'h0;
      preEmph <= 2'h0;
      idAddr <= 15'h0000;
    end else if (ce) begin
      hpdPrev <= next_hpdPrev;
      plugStatus <= next_plugStatus;
      plugEvent <= next_plugEvent;
      unplugEvent <= next_unplugEvent;
      irqCnt <= next_irqCnt;
      hpdDrive <= next_hpdDrive;
      pend <= next_pend;
      waitOn <= next_waitOn;
      waitCnt <= next_waitCnt;
      cmdLate <= next_cmdLate;
      sbPrev <= sbIn;
      psPrev <= powerSaveReq;
      lowPower <= next_lowPower;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      if (txValid && txReady) begin
        buffer[wrPtr] <= txWord;
      end
      txState <= next_txState;
      halfCnt <= next_halfCnt;
      halfIdx <= next_halfIdx;
      txShift <= next_txShift;
      sbOut <= next_sbOut;
      sbOe <= (next_txState != TX_IDLE);
      rxState <= next_rxState;
      runCnt <= next_runCnt;
      rxShift <= next_rxShift;
      bitCnt <= next_bitCnt;
      firstByte <= next_firstByte;
      rxValid <= next_rxValid;
      rxWord <= next_rxWord;
      driveLevel <= driveSet;
      preEmph <= preEmphSet;
      idAddr <= {idSegment, idOffset};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_plug_follows: assert property (ce && hpdUsed |=> plugStatus == $past(hpdIn))
    else $error("plug status does not follow line");
  a_event_pulls: assert property (ce && hpdEnable && sinkEvent && irqCnt == 20'h00000 |=> !hpdDrive)
    else $error("sink event did not pull line low");
  a_cmd_late: assert property (ce && waitOn && waitCnt == 20'(CMD_WAIT_CYC - 1) && !cmdRead |=> cmdLate)
    else $error("late command read not flagged");
  a_buffer_full: assert property (count == 2'h2 |-> !txReady && !(count > 2'h2))
    else $error("buffer overfilled");
  a_ctrl_clear: assert property (ce && laneIn[0].ctrl |=> laneOut[0] == $past(laneIn[0]))
    else $error("control symbol altered");
  a_half_duplex: assert property (sbOe |-> !rxValid && rxState == RX_HUNT)
    else $error("receiver active while driving");
  a_wake_fast: assert property (ce && lowPower && activity |=> !lowPower)
    else $error("no wake on sideband activity");
  a_lane_off: assert property (ce && laneCountM1 == 2'h0 |=> laneOut[3] == '0 && laneOut[1] == '0)
    else $error("disabled lane not quiet");
  a_id_addr: assert property (ce |=> idAddr[7:0] == $past(idOffset))
    else $error("identity address wrong");
  a_start_ctrl: assert property (ce && txState == TX_IDLE && next_txState == TX_PRE |-> head.ctrl)
    else $error("frame started without control bit");
  c_tx_frame: cover property (txState == TX_STOP ##1 txState == TX_IDLE);
  c_rx_byte: cover property (rxValid && !rxWord.ctrl);
  c_wake: cover property (lowPower ##1 !lowPower);
  c_buf_full: cover property (count == 2'h2);
endmodule // link_phy_hot_plug

// *** tb/sideband_partner.sv ***
// remote sideband end: manchester frame driver, line resolver, tx sampler
module sideband_partner
  import link_phy_pkg::*;
(
  input  wire logic clock,
  input  wire logic sbOut,
  input  wire logic sbOe,
  output logic      sbIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv    = 1'b0;
  logic lvl    = 1'b0;
  // idle line rests low, matching the receiver's reset level
  logic last   = 1'b1;
  logic oePrev = 1'b0;
  int   ph     = 0;
  logic halves[$];
  // a released line shows the inverse of its last level, never a stale copy
  assign sbIn = sbOe ? sbOut : (drv ? lvl : ~last);
  // halves are sampled mid-way, five cycles per half-bit
  always @(posedge clock) begin
    if (sbOe || drv) last <= sbIn;
    ph = (sbOe && oePrev) ? ph + 1 : 0;
    if (sbOe && (ph % 5 == 2)) halves.push_back(sbOut);
    oePrev = sbOe;
  end
  task automatic half(input logic v);
    lvl = v;
    repeat (5) @(posedge clock);
  endtask
  task automatic bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half(b[i]);
      half(~b[i]);
    end
  endtask
  task automatic mark();
    repeat (4) half(1'b0);
    repeat (4) half(1'b1);
  endtask
  task automatic send(input logic [7:0] d[3]);
    // never drive while the device holds the line
    while (sbOe !== 1'b0) @(posedge clock);
    #5;
    drv = 1'b1;
    bits(8'h00);
    bits(8'h00);
    mark();
    foreach (d[i]) bits(d[i]);
    mark();
    drv = 1'b0;
  endtask
endmodule // sideband_partner

// *** tb/tb_link_phy_hot_plug.sv ***
// self-checking bench for the link/phy boundary block
`include "link_phy_defs.svh"
module tb_link_phy_hot_plug
  import link_phy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CMDW = 50;
  localparam int IRQL = 8;
  logic clock = 1'b0;
  logic srst  = 1'b1;
  logic ce, hpdIn, hpdUsed, hpdEnable, sinkEvent, cmdPending, cmdRead;
  logic powerSaveReq, txValid, scrambleOn, sbIn;
  logic plugStatus, plugEvent, unplugEvent, hpdDrive, cmdLate, lowPower;
  logic sbReady, txReady, sbOut, sbOe, rxValid;
  logic [1:0] laneCountM1, driveSet, preEmphSet, driveLevel, preEmph;
  logic [`ID_SEG_BITS-1:0] idSegment;
  logic [`ID_OFS_BITS-1:0] idOffset;
  logic [14:0] idAddr;
  sb_word_t txWord, rxWord;
  lane_sym_t [`NUM_LANES-1:0] laneIn, laneOut;
  int mismatches = 0;
  int tests_run = 0;
  int nPlug = 0;
  int nUnplug = 0;
  int nLate = 0;
  int n, base;
  sb_word_t rxQ[$];
  sb_word_t expW[4];
  logic expH[$];
  logic [7:0] b[3];
  logic [31:0] seed = 32'he811;
  logic [31:0] r, q;
  logic [23:0] e;
  logic [15:0] lfsr[`NUM_LANES] = '{default: `SCR_SEED};
  // x^16+x^5+x^4+x^3+1, data bit 0 first; returns {state, data}
  function automatic logic [23:0] scrStep(input logic [7:0] d,
                                          input logic [15:0] s);
    logic [7:0] o;
    o = d;
    for (int k = 0; k < 8; k++) begin
      o[k] = d[k] ^ s[15];
      s = {s[14:0], 1'b0} ^ (s[15] ? 16'h0039 : 16'h0000);
    end
    return {s, o};
  endfunction

  link_phy_hot_plug #(.CMD_WAIT_CYC(CMDW), .IRQ_LOW_CYC(IRQL))
    u_link_phy_hot_plug (.clock(clock), .srst(srst), .ce(ce),
    .hpdIn(hpdIn), .hpdUsed(hpdUsed), .plugStatus(plugStatus),
    .plugEvent(plugEvent), .unplugEvent(unplugEvent),
    .hpdEnable(hpdEnable), .sinkEvent(sinkEvent), .cmdPending(cmdPending),
    .cmdRead(cmdRead), .hpdDrive(hpdDrive), .cmdLate(cmdLate),
    .powerSaveReq(powerSaveReq), .lowPower(lowPower), .sbReady(sbReady),
    .txWord(txWord), .txValid(txValid), .txReady(txReady), .sbOut(sbOut),
    .sbOe(sbOe), .sbIn(sbIn), .rxWord(rxWord), .rxValid(rxValid),
    .laneIn(laneIn), .laneCountM1(laneCountM1), .scrambleOn(scrambleOn),
    .laneOut(laneOut), .driveSet(driveSet), .preEmphSet(preEmphSet),
    .driveLevel(driveLevel), .preEmph(preEmph), .idSegment(idSegment),
    .idOffset(idOffset), .idAddr(idAddr));
  sideband_partner u_sideband_partner (.clock(clock), .sbOut(sbOut),
    .sbOe(sbOe), .sbIn(sbIn));

  initial begin
    forever #50 clock = ~clock;
  end
  // pulses are counted at the edge, before the design's updates land
  always @(posedge clock) begin
    if (srst === 1'b0 && plugEvent === 1'b1) nPlug++;
    if (srst === 1'b0 && unplugEvent === 1'b1) nUnplug++;
    if (srst === 1'b0 && cmdLate === 1'b1) nLate++;
    if (srst === 1'b0 && rxValid === 1'b1) rxQ.push_back(rxWord);
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic void addBits(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      expH.push_back(v[i]);
      expH.push_back(~v[i]);
    end
  endfunction
  function automatic void addMark();
    repeat (4) expH.push_back(1'b0);
    repeat (4) expH.push_back(1'b1);
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #5;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input sb_word_t w);
    txWord = w;
    txValid = 1'b1;
    for (int k = 0; k < 3000 && txReady !== 1'b1; k++) tick();
    tick();
  endtask
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    final_report();
  end

  initial begin
    {ce, hpdUsed} = 2'b11;
    {hpdIn, hpdEnable, sinkEvent, cmdPending, cmdRead} = 5'h00;
    {powerSaveReq, txValid, scrambleOn} = 3'h0;
    {laneCountM1, driveSet, preEmphSet} = 6'h00;
    {idSegment, idOffset, txWord, laneIn} = '0;
    tick(16);
    srst = 1'b0;
    tick();
    chk("txReady", 16'h1, 16'(txReady));
    chk("sbReady", 16'h0, 16'(sbReady));
    // a one-cycle glitch must reach the link layer untouched
    hpdIn = 1'b1;
    tick();
    chk("plugStatus", 16'h1, 16'(plugStatus));
    hpdIn = 1'b0;
    tick();
    chk("plugStatus", 16'h0, 16'(plugStatus));
    hpdIn = 1'b1;
    tick(4);
    chk("plugEvents", 16'h2, 16'(nPlug));
    chk("unplugEvents", 16'h1, 16'(nUnplug));
    {hpdUsed, hpdIn} = 2'b00;
    tick(3);
    chk("plugForced", 16'h1, 16'(plugStatus));
    hpdUsed = 1'b1;
    hpdEnable = 1'b1;
    tick(2);
    chk("sbReady", 16'h1, 16'(sbReady));
    for (int m = 0; m < 3; m++) begin
      if (m == 0) sinkEvent = 1'b1;
      else cmdPending = 1'b1;
      tick();
      {sinkEvent, cmdPending} = 2'b00;
      chk("sbReadyLow", 16'h0, 16'(sbReady));
      for (n = 0; hpdDrive === 1'b0 && n < 100; n++) tick();
      chk("hpdLowLen", 16'(IRQL), 16'(n));
      base = nLate;
      if (m == 2) tick(10);
      cmdRead = (m == 2);
      tick();
      cmdRead = 1'b0;
      for (n = 0; nLate == base && n < 2 * CMDW; n++) tick();
      // the read is only overdue when it never came
      if (m == 1) chk("lateTime", 16'h1, 16'(n >= CMDW - 3 && n <= CMDW + 2));
      chk("lateCount", 16'(m == 1), 16'(nLate - base));
    end
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      q = rnd();
      foreach (laneIn[l]) laneIn[l] = {q[l] & q[l+4], r[8*l +: 8]};
      {laneCountM1, scrambleOn, driveSet, preEmphSet} = q[15:9];
      {idSegment, idOffset} = q[31:17];
      tick();
      chk("driveLevel", 16'(driveSet), 16'(driveLevel));
      chk("preEmph", 16'(preEmphSet), 16'(preEmph));
      chk("idAddr", 16'({idSegment, idOffset}), 16'(idAddr));
      for (int l = 0; l < `NUM_LANES; l++) begin
        e = scrStep(laneIn[l].data, lfsr[l]);
        if (!laneIn[l].ctrl && scrambleOn) lfsr[l] = e[23:8];
        if (laneIn[l].ctrl && laneIn[l].data == `SCR_RESET_SYM)
          lfsr[l] = `SCR_SEED;
        if (l > laneCountM1) chk("laneOff", 16'h0, 16'(laneOut[l]));
        else if (laneIn[l].ctrl || !scrambleOn)
          chk("lanePass", 16'(laneIn[l]), 16'(laneOut[l]));
        else chk("laneData", 16'({1'b0, e[7:0]}), 16'(laneOut[l]));
      end
    end
    // clock enable low must freeze every register
    ce = 1'b0;
    q[1:0] = driveLevel;
    driveSet = ~q[1:0];
    tick();
    chk("ceHold", 16'(q[1:0]), 16'(driveLevel));
    ce = 1'b1;
    foreach (b[i]) b[i] = rnd() >> 8;
    expH.delete();
    addBits(8'h00);
    addBits(8'h00);
    addMark();
    foreach (b[i]) addBits(b[i]);
    addMark();
    u_sideband_partner.halves.delete();
    // stray data word outside a frame, then a back-to-back frame
    put('{1'b0, 8'h55});
    put('{1'b1, b[0]});
    put('{1'b0, b[1]});
    put('{1'b0, b[2]});
    put('{1'b1, 8'h00});
    txValid = 1'b0;
    for (n = 0; sbOe !== 1'b0 && n < 3000; n++) tick();
    tick(3);
    chk("txHalves", 16'(expH.size()), 16'(u_sideband_partner.halves.size()));
    n = 0;
    foreach (expH[i])
      if (i < u_sideband_partner.halves.size())
        n += (u_sideband_partner.halves[i] !== expH[i]);
    chk("txHalfErrs", 16'h0, 16'(n));
    tick(60);
    powerSaveReq = 1'b1;
    tick(3);
    chk("lowPower", 16'h1, 16'(lowPower));
    rxQ.delete();
    fork
      u_sideband_partner.send(b);
      for (n = 0; lowPower !== 1'b0 && n < 10000; n++) tick();
    join
    chk("wakeIn1ms", 16'h1, 16'(n < 10000));
    tick(100);
    expW = '{'{1'b1, b[0]}, '{1'b0, b[1]}, '{1'b0, b[2]}, '{1'b1, 8'h00}};
    chk("rxCount", 16'h4, 16'(rxQ.size()));
    foreach (expW[i])
      if (i < rxQ.size()) chk("rxWord", 16'(expW[i]), 16'(rxQ[i]));
    powerSaveReq = 1'b0;
    tick(3);
    chk("lowPowerOff", 16'h0, 16'(lowPower));
    final_report();
  end
endmodule // tb_link_phy_hot_plug
